// ---- logic/tpmc_meter.sv ----
`timescale 1ns/100ps
module tpmc_meter
(
    // clock and reset
    input  logic        clk_in,
    input  logic        rstn_in,
    // control
    input  logic        start_in,
    input  logic        abort_in,
    input  logic [3:0]  win_log2_in,
    // samples
    input  logic        smp_valid_in,
    input  logic [11:0] i_in,
    input  logic [11:0] q_in,
    // result
    output logic        done_out,
    output logic [8:0]  power_out
);
    logic        busy_ff;
    logic        fin_ff;
    logic [3:0]  win_ff;
    logic [15:0] cnt_ff;
    logic [38:0] acc_ff;
    logic [23:0] sq;
    logic [23:0] mean;
    logic [4:0]  msb;
    logic [3:0]  frac;
    logic [8:0]  lg;
    logic [17:0] prod;

    assign sq = 24'($signed(i_in) * $signed(i_in)) + 24'($signed(q_in) * $signed(q_in));
    assign mean = 24'(acc_ff >> win_ff);

    // log2: leading one plus four bits
    always_comb
    begin
        msb  = 5'h00;
        frac = 4'h0;
        for (int k = 0; k < 24; k++)
            if (mean[k])
                msb = 5'(k);
        frac = 4'((({mean, 4'h0}) >> msb) & 28'h000000f);
        lg   = {msb, frac};
        prod = 18'((tpmc_pkg::FS_LOG2_X16 - lg) * tpmc_pkg::DB_SCALE);
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            busy_ff <= 1'b0;
            fin_ff  <= 1'b0;
            win_ff  <= 4'h0;
            cnt_ff  <= 16'h0000;
            acc_ff  <= 39'h0;
        end
        else
        begin
            fin_ff <= 1'b0;
            if (abort_in)
                busy_ff <= 1'b0;
            else if (start_in)
            begin
                busy_ff <= 1'b1;
                win_ff  <= win_log2_in;
                cnt_ff  <= 16'h0000;
                acc_ff  <= 39'h0;
            end
            else if (busy_ff && smp_valid_in)
            begin
                acc_ff <= acc_ff + 39'(sq);
                cnt_ff <= cnt_ff + 16'h0001;
                if (cnt_ff == 16'((17'h00001 << win_ff) - 17'h00001))
                begin
                    busy_ff <= 1'b0;
                    fin_ff  <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            done_out  <= 1'b0;
            power_out <= tpmc_pkg::PWR_FLOOR;
        end
        else
        begin
            done_out <= fin_ff & ~abort_in;
            if (fin_ff)
            begin
                if (mean == 24'h000000)
                    power_out <= tpmc_pkg::PWR_FLOOR;
                else if (lg >= tpmc_pkg::FS_LOG2_X16)
                    power_out <= 9'h000;
                else
                    power_out <= prod[16:8];
            end
        end
    end

endmodule : tpmc_meter

// ---- logic/tpmc_pkg.sv ----
// Summary of operation
// - monitor only in tdd, reusing the idle receive chain
// - measurement starts when the enable state machine enters transmit
// - one measurement per transmit state, or repeated until it ends
// - rms over set window, as -dBFS power word at 0.25 dB/LSB
// - front-end gain: channel one 0x070[1:0], channel two 0x071[1:0]
// - front-end gain code: 00 open, 01 0 dB, 10 6 dB, 11 9.5 dB
// - low and high baseband gain indices in 0x067[4:0], 0x068[4:0]
// - 0x078[7:0] is the threshold choosing low or high gain mode
// - attenuation at or below threshold uses low index, above high
// - transimpedance amp gain switches with no software action
// - power words in 0x06b, 0x06c, 0x06d compensated for baseband gain
// - host sets 0x06e bits 7,5 and clears 0x057 bits 2,3 to power up
package tpmc_pkg;

    // register offsets
    localparam logic [9:0] ADDR_PD_OVR    = 10'h057;
    localparam logic [9:0] ADDR_LOW_GAIN  = 10'h067;
    localparam logic [9:0] ADDR_HIGH_GAIN = 10'h068;
    localparam logic [9:0] ADDR_RES_A     = 10'h06b;
    localparam logic [9:0] ADDR_RES_B     = 10'h06c;
    localparam logic [9:0] ADDR_RES_C     = 10'h06d;
    localparam logic [9:0] ADDR_MODE      = 10'h06e;
    localparam logic [9:0] ADDR_WINDOW    = 10'h06f;
    localparam logic [9:0] ADDR_MON1      = 10'h070;
    localparam logic [9:0] ADDR_MON2      = 10'h071;
    localparam logic [9:0] ADDR_ATT_A     = 10'h073;
    localparam logic [9:0] ADDR_ATT_B     = 10'h074;
    localparam logic [9:0] ADDR_THRESH    = 10'h078;
    localparam logic [9:0] ADDR_FB_A      = 10'h1db;
    localparam logic [9:0] ADDR_FB_B      = 10'h1dc;

    // field positions
    localparam int MODE_EN_HI  = 7;
    localparam int MODE_EN_LO  = 5;
    localparam int MODE_CONT   = 0;
    localparam int PD_BIT_A    = 2;
    localparam int PD_BIT_B    = 3;
    localparam int FB_A_BIT0   = 0;
    localparam int FB_A_BIT1   = 2;
    localparam int FB_B_BIT0   = 6;
    localparam int FB_B_BIT1   = 7;

    // reset values
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [7:0] RST_PD_OVR = 8'h0c;
    localparam logic [7:0] RST_WINDOW = 8'h04;

    // spi and arithmetic
    localparam logic [4:0] SPI_INSTR_BITS = 5'h10;
    localparam logic [4:0] SPI_LAST_BIT   = 5'h17;
    localparam logic [8:0] QDB_PER_STEP   = 9'h004;
    localparam logic [8:0] FS_LOG2_X16    = 9'h160;
    localparam logic [8:0] DB_SCALE       = 9'h0c1;
    localparam logic [8:0] PWR_FLOOR      = 9'h1ff;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MEAS = 2'b01,
        ST_HOLD = 2'b11
    } tpmc_state_t;

    typedef enum logic [1:0] {
        FE_OPEN = 2'b00,
        FE_0DB  = 2'b01,
        FE_6DB  = 2'b10,
        FE_9DB5 = 2'b11
    } tpmc_fe_gain_t;

    typedef struct packed {
        logic       wr;
        logic [9:0] addr;
        logic [7:0] wdata;
    } tpmc_bus_t;

    typedef struct packed {
        logic          input_open;
        tpmc_fe_gain_t fe;
        logic          tia_high;
        logic          high_mode;
        logic [4:0]    bbf_idx;
    } tpmc_gain_t;

endpackage : tpmc_pkg

// ---- logic/tpmc_spi_slave.sv ----
`timescale 1ns/100ps
module tpmc_spi_slave
(
    // clock and reset
    input  logic                clk_in,
    input  logic                rstn_in,
    // spi pins
    input  logic                sclk_in,
    input  logic                csn_in,
    input  logic                mosi_in,
    output logic                miso_out,
    output logic                miso_oe_out,
    // register side
    input  logic [7:0]          rdata_in,
    output logic [9:0]          rd_addr_out,
    output tpmc_pkg::tpmc_bus_t bus_out
);
    logic [2:0]  s1_ff;
    logic [2:0]  s2_ff;
    logic        sclk_d_ff;
    logic [4:0]  cnt_ff;
    logic [23:0] shift_ff;
    logic [7:0]  out_ff;
    logic        load_ff;
    logic        rise;
    logic        fall;
    logic        sel;

    // async pins
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            s1_ff     <= 3'h2;
            s2_ff     <= 3'h2;
            sclk_d_ff <= 1'b0;
        end
        else
        begin
            s1_ff     <= {mosi_in, csn_in, sclk_in};
            s2_ff     <= s1_ff;
            sclk_d_ff <= s2_ff[0];
        end
    end

    assign rise        = s2_ff[0] & ~sclk_d_ff;
    assign fall        = ~s2_ff[0] & sclk_d_ff;
    assign sel         = ~s2_ff[1];
    assign rd_addr_out = shift_ff[9:0];
    assign miso_out    = out_ff[7];

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            cnt_ff   <= 5'h00;
            shift_ff <= 24'h000000;
            load_ff  <= 1'b0;
            bus_out  <= '0;
        end
        else
        begin
            bus_out.wr <= 1'b0;
            load_ff    <= 1'b0;
            if (!sel)
                cnt_ff <= 5'h00;
            else if (rise)
            begin
                shift_ff <= {shift_ff[22:0], s2_ff[2]};
                cnt_ff   <= cnt_ff + 5'h01;
                // read answer loads after the instruction
                if (cnt_ff == tpmc_pkg::SPI_INSTR_BITS - 5'h01 && !shift_ff[14])
                    load_ff <= 1'b1;
                if (cnt_ff == tpmc_pkg::SPI_LAST_BIT && shift_ff[22])
                begin
                    bus_out.wr    <= 1'b1;
                    bus_out.addr  <= shift_ff[16:7];
                    bus_out.wdata <= {shift_ff[6:0], s2_ff[2]};
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            out_ff      <= 8'h00;
            miso_oe_out <= 1'b0;
        end
        else
        begin
            miso_oe_out <= sel;
            if (load_ff)
                out_ff <= rdata_in;
            else if (fall && cnt_ff > tpmc_pkg::SPI_INSTR_BITS)
                out_ff <= {out_ff[6:0], 1'b0};
        end
    end

endmodule : tpmc_spi_slave

// ---- logic/tpmc_top.sv ----
`timescale 1ns/100ps
module tpmc_top
(
    // clock and reset
    input  logic                 clk_in,
    input  logic                 rstn_in,
    // spi pins
    input  logic                 spi_clk_in,
    input  logic                 spi_csn_in,
    input  logic                 spi_mosi_in,
    output logic                 spi_miso_out,
    output logic                 spi_miso_oe_out,
    // device context, same clock domain
    input  logic                 tdd_mode_in,
    input  logic                 enable_state_machine_tx_state_in,
    // receive chain samples
    input  logic                 rx_valid_in,
    input  logic [11:0]          mon1_i_in,
    input  logic [11:0]          mon1_q_in,
    input  logic [11:0]          mon2_i_in,
    input  logic [11:0]          mon2_q_in,
    // analog controls
    output tpmc_pkg::tpmc_gain_t mon1_gain_out,
    output tpmc_pkg::tpmc_gain_t mon2_gain_out,
    output logic                 monitor_route_out,
    output logic                 monitor_powered_out,
    output logic                 amp_feedback_low_out,
    // status
    output logic                 meas_busy_out,
    output logic                 meas_done_out
);
    tpmc_pkg::tpmc_bus_t   bus;
    tpmc_pkg::tpmc_state_t state_ff;
    tpmc_pkg::tpmc_state_t nxt_state;

    logic [9:0] rd_addr;
    logic [7:0] rdata;
    logic [7:0] pd_ovr_ff;
    logic [7:0] low_gain_ff;
    logic [7:0] high_gain_ff;
    logic [7:0] mode_ff;
    logic [7:0] window_ff;
    logic [7:0] mon1_ff;
    logic [7:0] mon2_ff;
    logic [7:0] att_a_ff;
    logic [7:0] att_b_ff;
    logic [7:0] thresh_ff;
    logic [7:0] fb_a_ff;
    logic [7:0] fb_b_ff;
    logic [8:0] res1_ff;
    logic [8:0] res2_ff;
    logic       tx_d_ff;
    logic       high1_ff;
    logic       high2_ff;
    logic [4:0] idx1_snap_ff;
    logic [4:0] idx2_snap_ff;
    logic       tx_enter;
    logic       allowed;
    logic       start;
    logic       abort;
    logic       done1;
    logic       done2;
    logic       done2_seen_ff;
    logic       done1_seen_ff;
    logic [8:0] pwr1;
    logic [8:0] pwr2;
    logic [4:0] idx1;
    logic [4:0] idx2;

    // saturating gain add onto -dBFS word
    function automatic logic [8:0] comp_word(input logic [8:0] pwr, input logic [4:0] idx);
        logic [9:0] sum;
        sum = {1'b0, pwr} + 10'(idx * tpmc_pkg::QDB_PER_STEP);
        if (sum[9])
            comp_word = tpmc_pkg::PWR_FLOOR;
        else
            comp_word = sum[8:0];
    endfunction : comp_word

    tpmc_spi_slave u_spi
    (
        .clk_in      (clk_in),
        .rstn_in     (rstn_in),
        .sclk_in     (spi_clk_in),
        .csn_in      (spi_csn_in),
        .mosi_in     (spi_mosi_in),
        .miso_out    (spi_miso_out),
        .miso_oe_out (spi_miso_oe_out),
        .rdata_in    (rdata),
        .rd_addr_out (rd_addr),
        .bus_out     (bus)
    );

    // register writes
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pd_ovr_ff    <= tpmc_pkg::RST_PD_OVR;
            low_gain_ff  <= tpmc_pkg::RST_ZERO;
            high_gain_ff <= tpmc_pkg::RST_ZERO;
            mode_ff      <= tpmc_pkg::RST_ZERO;
            window_ff    <= tpmc_pkg::RST_WINDOW;
            mon1_ff      <= tpmc_pkg::RST_ZERO;
            mon2_ff      <= tpmc_pkg::RST_ZERO;
            att_a_ff     <= tpmc_pkg::RST_ZERO;
            att_b_ff     <= tpmc_pkg::RST_ZERO;
            thresh_ff    <= tpmc_pkg::RST_ZERO;
            fb_a_ff      <= tpmc_pkg::RST_ZERO;
            fb_b_ff      <= tpmc_pkg::RST_ZERO;
        end
        else if (bus.wr)
        begin
            case (bus.addr)
                tpmc_pkg::ADDR_PD_OVR:    pd_ovr_ff    <= bus.wdata;
                tpmc_pkg::ADDR_LOW_GAIN:  low_gain_ff  <= bus.wdata;
                tpmc_pkg::ADDR_HIGH_GAIN: high_gain_ff <= bus.wdata;
                tpmc_pkg::ADDR_MODE:      mode_ff      <= bus.wdata;
                tpmc_pkg::ADDR_WINDOW:    window_ff    <= bus.wdata;
                tpmc_pkg::ADDR_MON1:      mon1_ff      <= bus.wdata;
                tpmc_pkg::ADDR_MON2:      mon2_ff      <= bus.wdata;
                tpmc_pkg::ADDR_ATT_A:     att_a_ff     <= bus.wdata;
                tpmc_pkg::ADDR_ATT_B:     att_b_ff     <= bus.wdata;
                tpmc_pkg::ADDR_THRESH:    thresh_ff    <= bus.wdata;
                tpmc_pkg::ADDR_FB_A:      fb_a_ff      <= bus.wdata;
                tpmc_pkg::ADDR_FB_B:      fb_b_ff      <= bus.wdata;
                default:                  ;
            endcase
        end
    end

    // reads; unmapped read zero
    always_comb
    begin
        case (rd_addr)
            tpmc_pkg::ADDR_PD_OVR:    rdata = pd_ovr_ff;
            tpmc_pkg::ADDR_LOW_GAIN:  rdata = low_gain_ff;
            tpmc_pkg::ADDR_HIGH_GAIN: rdata = high_gain_ff;
            // compensated words, high bits then low
            tpmc_pkg::ADDR_RES_A:     rdata = res1_ff[8:1];
            tpmc_pkg::ADDR_RES_B:     rdata = res2_ff[8:1];
            tpmc_pkg::ADDR_RES_C:     rdata = {6'h00, res2_ff[0], res1_ff[0]};
            tpmc_pkg::ADDR_MODE:      rdata = mode_ff;
            tpmc_pkg::ADDR_WINDOW:    rdata = window_ff;
            tpmc_pkg::ADDR_MON1:      rdata = mon1_ff;
            tpmc_pkg::ADDR_MON2:      rdata = mon2_ff;
            tpmc_pkg::ADDR_ATT_A:     rdata = att_a_ff;
            tpmc_pkg::ADDR_ATT_B:     rdata = att_b_ff;
            tpmc_pkg::ADDR_THRESH:    rdata = thresh_ff;
            tpmc_pkg::ADDR_FB_A:      rdata = fb_a_ff;
            tpmc_pkg::ADDR_FB_B:      rdata = fb_b_ff;
            default:                  rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            high1_ff <= 1'b0;
            high2_ff <= 1'b0;
        end
        else
        begin
            high1_ff <= att_a_ff > thresh_ff;
            high2_ff <= att_b_ff > thresh_ff;
        end
    end

    assign idx1 = high1_ff ? high_gain_ff[4:0] : low_gain_ff[4:0];
    assign idx2 = high2_ff ? high_gain_ff[4:0] : low_gain_ff[4:0];

    assign monitor_powered_out = ~pd_ovr_ff[tpmc_pkg::PD_BIT_A] & ~pd_ovr_ff[tpmc_pkg::PD_BIT_B];
    // tdd only, both enable bits set
    assign allowed = tdd_mode_in & mode_ff[tpmc_pkg::MODE_EN_HI] & mode_ff[tpmc_pkg::MODE_EN_LO]
                     & monitor_powered_out;
    // low feedback needs all four bits
    assign amp_feedback_low_out = fb_a_ff[tpmc_pkg::FB_A_BIT0] & fb_a_ff[tpmc_pkg::FB_A_BIT1]
                                  & fb_b_ff[tpmc_pkg::FB_B_BIT0] & fb_b_ff[tpmc_pkg::FB_B_BIT1];

    always_comb
    begin
        mon1_gain_out.fe         = tpmc_pkg::tpmc_fe_gain_t'(mon1_ff[1:0]);
        mon1_gain_out.input_open = mon1_ff[1:0] == tpmc_pkg::FE_OPEN;
        mon1_gain_out.tia_high   = high1_ff;
        mon1_gain_out.high_mode  = high1_ff;
        mon1_gain_out.bbf_idx    = idx1;
        mon2_gain_out.fe         = tpmc_pkg::tpmc_fe_gain_t'(mon2_ff[1:0]);
        mon2_gain_out.input_open = mon2_ff[1:0] == tpmc_pkg::FE_OPEN;
        mon2_gain_out.tia_high   = high2_ff;
        mon2_gain_out.high_mode  = high2_ff;
        mon2_gain_out.bbf_idx    = idx2;
    end

    assign tx_enter = enable_state_machine_tx_state_in & ~tx_d_ff;
    // tx exit or enable loss drops partial window
    assign abort = (state_ff != tpmc_pkg::ST_IDLE) & (~enable_state_machine_tx_state_in | ~allowed);

    always_comb
    begin
        nxt_state = state_ff;
        start     = 1'b0;
        case (state_ff)
            tpmc_pkg::ST_IDLE:
            begin
                if (tx_enter && allowed)
                begin
                    nxt_state = tpmc_pkg::ST_MEAS;
                    start     = 1'b1;
                end
            end
            tpmc_pkg::ST_MEAS:
            begin
                if (abort)
                    nxt_state = tpmc_pkg::ST_IDLE;
                else if (done1_seen_ff && done2_seen_ff)
                begin
                    if (mode_ff[tpmc_pkg::MODE_CONT])
                        start = 1'b1;
                    else
                        nxt_state = tpmc_pkg::ST_HOLD;
                end
            end
            tpmc_pkg::ST_HOLD:
            begin
                if (!enable_state_machine_tx_state_in)
                    nxt_state = tpmc_pkg::ST_IDLE;
            end
            default: nxt_state = tpmc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state_ff <= tpmc_pkg::ST_IDLE;
            tx_d_ff  <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            tx_d_ff  <= enable_state_machine_tx_state_in;
        end
    end

    assign monitor_route_out = state_ff == tpmc_pkg::ST_MEAS;
    assign meas_busy_out     = state_ff == tpmc_pkg::ST_MEAS;

    // channels share the window, finishing together
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            done1_seen_ff <= 1'b0;
            done2_seen_ff <= 1'b0;
            idx1_snap_ff  <= 5'h00;
            idx2_snap_ff  <= 5'h00;
        end
        else if (start || abort)
        begin
            done1_seen_ff <= 1'b0;
            done2_seen_ff <= 1'b0;
            idx1_snap_ff  <= idx1;
            idx2_snap_ff  <= idx2;
        end
        else
        begin
            done1_seen_ff <= done1_seen_ff | done1;
            done2_seen_ff <= done2_seen_ff | done2;
        end
    end

    tpmc_meter u_meter1
    (
        .clk_in       (clk_in),
        .rstn_in      (rstn_in),
        .start_in     (start),
        .abort_in     (abort),
        .win_log2_in  (window_ff[3:0]),
        .smp_valid_in (rx_valid_in),
        .i_in         (mon1_i_in),
        .q_in         (mon1_q_in),
        .done_out     (done1),
        .power_out    (pwr1)
    );

    tpmc_meter u_meter2
    (
        .clk_in       (clk_in),
        .rstn_in      (rstn_in),
        .start_in     (start),
        .abort_in     (abort),
        .win_log2_in  (window_ff[3:0]),
        .smp_valid_in (rx_valid_in),
        .i_in         (mon2_i_in),
        .q_in         (mon2_q_in),
        .done_out     (done2),
        .power_out    (pwr2)
    );

    // compensate with index held from window start
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            res1_ff       <= tpmc_pkg::PWR_FLOOR;
            res2_ff       <= tpmc_pkg::PWR_FLOOR;
            meas_done_out <= 1'b0;
        end
        else
        begin
            meas_done_out <= done2;
            if (done1)
                res1_ff <= comp_word(pwr1, idx1_snap_ff);
            if (done2)
                res2_ff <= comp_word(pwr2, idx2_snap_ff);
        end
    end

endmodule : tpmc_top

// ---- tb/test_tx_power_monitor_ctrl.sv ----
`timescale 1ns/100ps
module test_tx_power_monitor_ctrl;
    logic clk_in, rstn_in, tdd, enable_state_machine, rxv, sclk, csn, mosi, miso, oe, amp, pwr, route, busy, done;
    logic [11:0]          i1;
    logic [7:0]           rd;
    tpmc_pkg::tpmc_gain_t g1, g2;
    int                   n_mismatch = 0;
    int                   compares = 0;
    // {write, address, data, expected read}
    logic [26:0] rows [10] = '{{1'b0,10'h057,8'h00,8'h0c}, {1'b0,10'h06f,8'h00,8'h04},
        {1'b0,10'h06d,8'h00,8'h03}, {1'b0,10'h06b,8'h00,8'hff}, {1'b1,10'h06b,8'h55,8'hff},
        {1'b1,10'h067,8'h02,8'h02}, {1'b1,10'h068,8'h11,8'h11}, {1'b1,10'h078,8'h20,8'h20},
        {1'b1,10'h100,8'haa,8'h00}, {1'b1,10'h057,8'h00,8'h00}};
    // channel two idle: result at floor
    tpmc_top dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .spi_clk_in(sclk), .spi_csn_in(csn),
        .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(oe), .tdd_mode_in(tdd),
        .enable_state_machine_tx_state_in(enable_state_machine), .rx_valid_in(rxv), .mon1_i_in(i1), .mon1_q_in(12'h000),
        .mon2_i_in(12'h000), .mon2_q_in(12'h000), .mon1_gain_out(g1), .mon2_gain_out(g2),
        .monitor_route_out(route), .monitor_powered_out(pwr), .amp_feedback_low_out(amp),
        .meas_busy_out(busy), .meas_done_out(done));
    tpmc_host host_u (.clk_in(clk_in), .miso_in(oe ? miso : ~miso), .sclk_out(sclk),
        .csn_out(csn), .mosi_out(mosi));
    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    task automatic wrap_up;
        $display("counts compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    task automatic chk_pin(input logic [9:0] got, input logic [9:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_pin
    task automatic chk_reg(input logic [9:0] a, input logic [7:0] exp);
        host_u.xfer(1'b0, a, 8'h00, rd);
        chk_pin({2'b00, rd}, {2'b00, exp});
    endtask : chk_reg
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        host_u.xfer(1'b1, a, d, rd);
        repeat (4) @(negedge clk_in);
    endtask : wr
    task automatic feed(input int n);
        repeat (n)
        begin
            @(negedge clk_in);
            rxv = 1'b1;
            @(negedge clk_in);
            rxv = 1'b0;
        end
    endtask : feed
    task automatic watch(input int n, output int k);
        k = 0;
        repeat (n)
        begin
            @(posedge clk_in);
            #1;
            if (done === 1'b1)
                k++;
        end
        @(negedge clk_in);
    endtask : watch
    task automatic wait_done;
        int k;
        for (k = 0; k < 40 && done !== 1'b1; k++)
        begin
            @(posedge clk_in);
            #1;
        end
        if (k == 40)
        begin
            n_mismatch++;
            wrap_up();
        end
        @(negedge clk_in);
    endtask : wait_done
    initial
    begin
        #2_000_000;
        n_mismatch++;
        wrap_up();
    end
    initial
    begin
        int k;
        rstn_in = 1'b0;
        tdd = 1'b0;
        enable_state_machine = 1'b0;
        rxv = 1'b0;
        i1 = 12'h200;
        repeat (4) @(negedge clk_in);
        rstn_in = 1'b1;
        repeat (4) @(negedge clk_in);
        foreach (rows[r])
        begin
            if (rows[r][26])
                wr(rows[r][25:16], rows[r][15:8]);
            chk_reg(rows[r][25:16], rows[r][7:0]);
        end
        chk_pin(pwr, 10'h001);
        $display("test registers done");
        for (int f = 0; f < 4; f++)
        begin
            wr(10'h070, f[7:0]);
            chk_pin({g1.input_open, g1.fe}, {f == 0, f[1:0]});
        end
        wr(10'h071, 8'h02);
        chk_pin({g2.input_open, g2.fe}, 10'h002);
        wr(10'h073, 8'h20);
        chk_pin(g1[6:0], 10'h002);
        wr(10'h073, 8'h21);
        chk_pin(g1[6:0], 10'h071);
        chk_pin(g2[6:0], 10'h002);
        wr(10'h078, 8'h21);
        chk_pin(g1[6:0], 10'h002);
        wr(10'h1db, 8'h05);
        wr(10'h1dc, 8'hc0);
        chk_pin(amp, 10'h001);
        wr(10'h1dc, 8'h40);
        chk_pin(amp, 10'h000);
        $display("test gains done");
        wr(10'h06f, 8'h02);
        wr(10'h06e, 8'ha0);
        enable_state_machine = 1'b1;
        repeat (4) @(negedge clk_in);
        chk_pin(busy, 10'h000);
        enable_state_machine = 1'b0;
        tdd = 1'b1;
        @(negedge clk_in);
        enable_state_machine = 1'b1;
        repeat (2) @(negedge clk_in);
        chk_pin(busy, 10'h001);
        feed(4);
        wait_done();
        watch(8, k);
        chk_pin({busy, k[8:0]}, 10'h000);
        // 2^18 power: 48 + 8 quarter-dB
        chk_reg(10'h06b, 8'h1c);
        chk_reg(10'h06c, 8'hff);
        chk_reg(10'h06d, 8'h02);
        enable_state_machine = 1'b0;
        wr(10'h06e, 8'ha1);
        enable_state_machine = 1'b1;
        feed(4);
        wait_done();
        feed(4);
        wait_done();
        feed(2);
        enable_state_machine = 1'b0;
        watch(10, k);
        chk_pin({busy, k[8:0]}, 10'h000);
        $display("test measure done");
        rstn_in = 1'b0;
        @(negedge clk_in);
        chk_pin({busy, pwr, g1.high_mode}, 10'h000);
        rstn_in = 1'b1;
        repeat (3) @(negedge clk_in);
        chk_reg(10'h067, 8'h00);
        $display("test reset done");
        wrap_up();
    end
endmodule : test_tx_power_monitor_ctrl

// ---- tb/tpmc_chk.sv ----
`timescale 1ns/100ps
module tpmc_chk
(
    input logic                 clk_in,
    input logic                 rstn_in,
    input logic                 tdd_mode_in,
    input logic                 enable_state_machine_tx_state_in,
    input tpmc_pkg::tpmc_gain_t mon1_gain_out,
    input tpmc_pkg::tpmc_gain_t mon2_gain_out,
    input logic                 monitor_route_out,
    input logic                 monitor_powered_out,
    input logic                 meas_busy_out,
    input logic                 meas_done_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    route_busy_a: assert property (monitor_route_out == meas_busy_out)
        else $error("route and busy differ");
    tdd_only_a: assert property ($rose(meas_busy_out) |-> $past(tdd_mode_in))
        else $error("measurement outside tdd");
    start_edge_a: assert property ($rose(meas_busy_out) |->
        $past(enable_state_machine_tx_state_in) && !$past(enable_state_machine_tx_state_in, 2))
        else $error("start without tx entry");
    powered_start_a: assert property ($rose(meas_busy_out) |-> $past(monitor_powered_out))
        else $error("start while powered down");
    tx_drop_a: assert property (!enable_state_machine_tx_state_in |=> !meas_busy_out)
        else $error("busy after tx exit");
    done_pulse_a: assert property (meas_done_out |=> !meas_done_out)
        else $error("done too long");
    done_after_a: assert property (meas_done_out |-> $past(meas_busy_out, 3))
        else $error("done without measuring");
    tia_follow_a: assert property (mon1_gain_out.tia_high == mon1_gain_out.high_mode &&
        mon2_gain_out.tia_high == mon2_gain_out.high_mode)
        else $error("amp gain off mode");
    open_input_a: assert property (
        mon1_gain_out.input_open == (mon1_gain_out.fe == tpmc_pkg::FE_OPEN) &&
        mon2_gain_out.input_open == (mon2_gain_out.fe == tpmc_pkg::FE_OPEN))
        else $error("open flag wrong");
    cover property ($rose(meas_busy_out));
    cover property (meas_done_out);
    cover property ($fell(meas_busy_out) && enable_state_machine_tx_state_in);
endmodule : tpmc_chk
bind tpmc_top tpmc_chk chk_u (.clk_in, .rstn_in, .tdd_mode_in, .enable_state_machine_tx_state_in,
    .mon1_gain_out, .mon2_gain_out, .monitor_route_out, .monitor_powered_out,
    .meas_busy_out, .meas_done_out);

// ---- tb/tpmc_host.sv ----
`timescale 1ns/100ps
module tpmc_host
(
    // clock
    input  logic clk_in,
    // spi pins
    input  logic miso_in,
    output logic      sclk_out,
    output logic      csn_out,
    output logic      mosi_out
);
    localparam int HALF = 10;
    initial
    begin
        sclk_out = 1'b0;
        csn_out  = 1'b1;
        mosi_out = 1'b0;
    end
    // host runs one 24-bit read or write frame
    task automatic xfer(input logic wr, input logic [9:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
        logic [23:0] frame;
        frame = {wr, 5'h00, addr, wdata};
        @(negedge clk_in);
        csn_out = 1'b0;
        for (int b = 23; b >= 0; b--)
        begin
            mosi_out = frame[b];
            repeat (HALF) @(negedge clk_in);
            sclk_out = 1'b1;
            if (b < 8)
                rdata[b] = miso_in;
            repeat (HALF) @(negedge clk_in);
            sclk_out = 1'b0;
        end
        mosi_out = ~mosi_out;
        csn_out  = 1'b1;
        repeat (8) @(negedge clk_in);
    endtask : xfer
endmodule : tpmc_host
